// ### hw/dlb_pkg.sv
package dlb_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] DLB_OFS_PLL_CONTROL = 8'h0d;
  localparam logic [7:0] DLB_OFS_RX_LANE_CONFIG = 8'h10;
  localparam logic [7:0] DLB_OFS_RX_EQUALIZATION = 8'h11;
  localparam logic [7:0] DLB_OFS_RX_CLOCK_RANGE = 8'h12;
  localparam logic [7:0] DLB_OFS_LVDS_OUTPUT_FORMAT = 8'h18;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int DLB_POS_PLL_ENABLE = 0;
  localparam int DLB_POS_LANE_COUNT = 3;
  localparam int DLB_POS_LEADER_TOL_OFF = 0;
  localparam int DLB_POS_DATA_EQ = 6;
  localparam int DLB_POS_CLOCK_EQ = 2;
  localparam int DLB_POS_DE_LOW = 7;
  localparam int DLB_POS_HS_LOW = 6;
  localparam int DLB_POS_VS_LOW = 5;
  localparam int DLB_POS_DEPTH_24 = 3;

  // ----------------------------------------
  // values after reset
  // ----------------------------------------
  localparam logic [7:0] DLB_RST_PLL_CONTROL = 8'h00;
  localparam logic [7:0] DLB_RST_RX_LANE_CONFIG = 8'h38;
  localparam logic [7:0] DLB_RST_RX_EQUALIZATION = 8'h00;
  localparam logic [7:0] DLB_RST_RX_CLOCK_RANGE = 8'h00;
  localparam logic [7:0] DLB_RST_LVDS_OUTPUT_FORMAT = 8'h70;

  // ----------------------------------------
  // equalization codes
  // ----------------------------------------
  localparam logic [1:0] DLB_EQ_NONE = 2'h0;
  localparam logic [1:0] DLB_EQ_1DB = 2'h1;
  localparam logic [1:0] DLB_EQ_2DB = 2'h3;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dlb_req_t;

  typedef struct packed {
    logic [3:0] lanes_on;
    logic leader_tol_off;
    logic [1:0] data_eq_db;
    logic [1:0] clock_eq_db;
    logic [7:0] clock_range_code;
  } dlb_rx_cfg_t;

  typedef struct packed {
    logic de_active_low;
    logic hs_active_low;
    logic vs_active_low;
    logic depth_24;
    logic fourth_lvds_data_pair_on;
  } dlb_lvds_cfg_t;

endpackage

// ### hw/dlb_eq_decode.sv
`timescale 1ns/1ps
`default_nettype none
// maps an equalization code to dB; the reserved code gives zero
module dlb_eq_decode
  import dlb_pkg::*;
(
  input wire logic [1:0] code,
  output logic [1:0] db
);
  always_comb
  begin
    case (code)
      DLB_EQ_1DB: db = 2'h1; // [R6]
      DLB_EQ_2DB: db = 2'h2; // [R6]
      default: db = 2'h0; // [R6] [R15]
    endcase
  end
endmodule
`default_nettype wire

// ### hw/dlb_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [R1] pll enable bit starts the pll with clock settings; clear stops it; resets 0
// [R2] host clears pll enable before changing clock source, divider or multiplier
// [R3] host sets pll enable only after input clock is stable
// [R4] lane count 00..11 gives four..one lanes; resets to one lane
// [R5] tolerance off bit 0 accepts one leader bit error, 1 accepts none
// [R6] equalization codes: 00 none, 01 1 dB, 11 2 dB; reset 00
// [R7] host programs clock range code 0x08..0x64 in 5 MHz steps
// [R8] de polarity bit 0 drives de high during active pixels, 1 low
// [R9] hsync polarity bit resets 1 for active low; 0 gives active high
// [R10] vsync polarity bit resets 1 for active low; 0 gives active high
// [R11] depth bit 0 forces 18 bpp, fourth lane off; 1 forces 24 bpp
// [R12] host leaves reserved fields at reset values
// [R13] host issues soft reset after changing configuration
// [R14] all registers readable and writable through the local serial slave
// [R15] reserved codes stored unchanged; their effect is undefined
module dlb_config_regs
  import dlb_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire dlb_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  output logic pll_enable,
  output dlb_rx_cfg_t rx_cfg,
  output dlb_lvds_cfg_t lvds_cfg
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] pll_control;
    logic [7:0] rx_lane_config;
    logic [7:0] rx_equalization;
    logic [7:0] rx_clock_range;
    logic [7:0] lvds_output_format;
    logic [7:0] rdata;
    logic rvalid;
    logic pll_enable;
    dlb_rx_cfg_t rx_cfg;
    dlb_lvds_cfg_t lvds_cfg;
  } dlb_state_t;

  localparam dlb_state_t DLB_STATE_RESET = '{
    pll_control: DLB_RST_PLL_CONTROL,
    rx_lane_config: DLB_RST_RX_LANE_CONFIG,
    rx_equalization: DLB_RST_RX_EQUALIZATION,
    rx_clock_range: DLB_RST_RX_CLOCK_RANGE,
    lvds_output_format: DLB_RST_LVDS_OUTPUT_FORMAT,
    rdata: 8'h00,
    rvalid: 1'b0,
    pll_enable: 1'b0,
    rx_cfg: '{lanes_on: 4'h1, leader_tol_off: 1'b0, data_eq_db: 2'h0,
              clock_eq_db: 2'h0, clock_range_code: 8'h00},
    lvds_cfg: '{de_active_low: 1'b0, hs_active_low: 1'b1, vs_active_low: 1'b1,
                depth_24: 1'b0, fourth_lvds_data_pair_on: 1'b0}
  };

  dlb_state_t state_q;
  dlb_state_t state_d;
  logic [1:0] data_eq_db;
  logic [1:0] clock_eq_db;

  // ----------------------------------------
  // equalization decode
  // ----------------------------------------
  dlb_eq_decode u_data_eq (
    .code(state_q.rx_equalization[DLB_POS_DATA_EQ +: 2]),
    .db(data_eq_db)
  );

  dlb_eq_decode u_clock_eq (
    .code(state_q.rx_equalization[DLB_POS_CLOCK_EQ +: 2]),
    .db(clock_eq_db)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    logic [1:0] lane_code;
    lane_code = 2'h0;
    state_d = state_q;
    // whole bytes stored, reserved bits and codes included [R14] [R15]
    if (req.wr)
    begin
      case (req.addr)
        DLB_OFS_PLL_CONTROL: state_d.pll_control = req.wdata; // [R14]
        DLB_OFS_RX_LANE_CONFIG: state_d.rx_lane_config = req.wdata;
        DLB_OFS_RX_EQUALIZATION: state_d.rx_equalization = req.wdata;
        DLB_OFS_RX_CLOCK_RANGE: state_d.rx_clock_range = req.wdata; // [R15]
        DLB_OFS_LVDS_OUTPUT_FORMAT: state_d.lvds_output_format = req.wdata;
        default: state_d.pll_control = state_q.pll_control;
      endcase
    end
    // read returns stored value; unmapped reads as zero [R14]
    state_d.rvalid = req.rd;
    if (req.rd)
    begin
      case (req.addr)
        DLB_OFS_PLL_CONTROL: state_d.rdata = state_q.pll_control;
        DLB_OFS_RX_LANE_CONFIG: state_d.rdata = state_q.rx_lane_config;
        DLB_OFS_RX_EQUALIZATION: state_d.rdata = state_q.rx_equalization;
        DLB_OFS_RX_CLOCK_RANGE: state_d.rdata = state_q.rx_clock_range;
        DLB_OFS_LVDS_OUTPUT_FORMAT: state_d.rdata = state_q.lvds_output_format;
        default: state_d.rdata = 8'h00;
      endcase
    end
    // decoded controls follow stored fields one cycle later
    state_d.pll_enable = state_q.pll_control[DLB_POS_PLL_ENABLE]; // [R1]
    lane_code = state_q.rx_lane_config[DLB_POS_LANE_COUNT +: 2];
    case (lane_code) // [R4]
      2'h0: state_d.rx_cfg.lanes_on = 4'hf;
      2'h1: state_d.rx_cfg.lanes_on = 4'h7;
      2'h2: state_d.rx_cfg.lanes_on = 4'h3;
      default: state_d.rx_cfg.lanes_on = 4'h1;
    endcase
    state_d.rx_cfg.leader_tol_off = state_q.rx_lane_config[DLB_POS_LEADER_TOL_OFF]; // [R5]
    state_d.rx_cfg.data_eq_db = data_eq_db; // [R6]
    state_d.rx_cfg.clock_eq_db = clock_eq_db; // [R6]
    // range code passed raw; range checking is the host's job
    state_d.rx_cfg.clock_range_code = state_q.rx_clock_range; // [R15]
    state_d.lvds_cfg.de_active_low = state_q.lvds_output_format[DLB_POS_DE_LOW]; // [R8]
    state_d.lvds_cfg.hs_active_low = state_q.lvds_output_format[DLB_POS_HS_LOW]; // [R9]
    state_d.lvds_cfg.vs_active_low = state_q.lvds_output_format[DLB_POS_VS_LOW]; // [R10]
    state_d.lvds_cfg.depth_24 = state_q.lvds_output_format[DLB_POS_DEPTH_24]; // [R11]
    state_d.lvds_cfg.fourth_lvds_data_pair_on =
      state_q.lvds_output_format[DLB_POS_DEPTH_24]; // [R11]
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      state_q <= DLB_STATE_RESET;
    else
      state_q <= state_d;
  end

  assign rdata = state_q.rdata;
  assign rvalid = state_q.rvalid;
  assign pll_enable = state_q.pll_enable;
  assign rx_cfg = state_q.rx_cfg;
  assign lvds_cfg = state_q.lvds_cfg;

endmodule
`default_nettype wire

// ### tb/dlb_props.sv
`timescale 1ns/1ps
`default_nettype none
module dlb_props
  import dlb_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire dlb_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic pll_enable,
  input wire dlb_rx_cfg_t rx_cfg,
  input wire dlb_lvds_cfg_t lvds_cfg
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  function automatic logic [1:0] eqdb(logic [1:0] c);
    return {c[1] & c[0], c[0] & ~c[1]};
  endfunction
  sequence s_wr(a);
    req.wr && req.addr == a;
  endsequence
  AST_PLL: assert property (s_wr(DLB_OFS_PLL_CONTROL) |-> ##2 pll_enable == $past(req.wdata[0], 2))
    else $error("pll enable wrong");
  AST_LANES: assert property (s_wr(DLB_OFS_RX_LANE_CONFIG) |-> ##2
    rx_cfg.lanes_on == 4'hf >> $past(req.wdata[4:3], 2)) else $error("lane mask wrong");
  AST_TOL: assert property (s_wr(DLB_OFS_RX_LANE_CONFIG) |-> ##2
    rx_cfg.leader_tol_off == $past(req.wdata[0], 2)) else $error("tolerance bit wrong");
  AST_EQ: assert property (s_wr(DLB_OFS_RX_EQUALIZATION) |-> ##2
    rx_cfg.data_eq_db == eqdb($past(req.wdata[7:6], 2))
    && rx_cfg.clock_eq_db == eqdb($past(req.wdata[3:2], 2))) else $error("eq decode wrong");
  AST_RANGE: assert property (s_wr(DLB_OFS_RX_CLOCK_RANGE) |-> ##2
    rx_cfg.clock_range_code == $past(req.wdata, 2)) else $error("range code wrong");
  AST_LVDS: assert property (s_wr(DLB_OFS_LVDS_OUTPUT_FORMAT) |-> ##2
    lvds_cfg == {$past(req.wdata[7:5], 2), {2{$past(req.wdata[3], 2)}}}) else $error("lvds cfg wrong");
  AST_RD: assert property (req.rd |=> rvalid) else $error("no read answer");
  AST_HOLD: assert property (!rvalid |-> $stable(rdata)) else $error("rdata moved");
  AST_UNMAP: assert property (req.rd && req.addr == 8'h00 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_RST: assert property ($rose(reset_n) |-> !pll_enable && rx_cfg == 17'h02000
    && lvds_cfg == 5'b01100) else $error("reset outputs wrong");
endmodule
bind dlb_config_regs dlb_props u_props (.mclk(mclk), .reset_n(reset_n), .req(req), .rdata(rdata),
  .rvalid(rvalid), .pll_enable(pll_enable), .rx_cfg(rx_cfg), .lvds_cfg(lvds_cfg));
`default_nettype wire

// ### tb/dlb_host.sv
`timescale 1ns/1ps
`default_nettype none
module dlb_host
  import dlb_pkg::*;
(
  input wire logic mclk,
  output dlb_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  initial req = '0;
  // single bytes; clock, reserved-field and soft reset order is left to the caller
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n = 0;
    @(posedge mclk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: req.wdata};
    @(posedge mclk);
    req.rd <= 1'b0;
    @(negedge mclk);
    while (rvalid !== 1'b1 && n < 4)
    begin
      @(negedge mclk);
      n++;
    end
    d = rdata;
  endtask
endmodule
`default_nettype wire

// ### tb/dlb_config_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dlb_config_regs_tb;
  import dlb_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  dlb_req_t req;
  logic [7:0] rdata, d;
  logic rvalid, pll_enable;
  dlb_rx_cfg_t rx_cfg;
  dlb_lvds_cfg_t lvds_cfg;
  int n_errors = 0;
  int checks = 0;
  int i;
  logic [31:0] seed = 32'h38b4;
  logic [31:0] r;
  logic [7:0] ofs [5] = '{8'h0d, 8'h10, 8'h11, 8'h12, 8'h18};
  logic [7:0] rst [5] = '{8'h00, 8'h38, 8'h00, 8'h00, 8'h70};
  logic [7:0] m [5];
  always #10 mclk = ~mclk;
  dlb_config_regs uut (.mclk(mclk), .reset_n(reset_n), .req(req), .rdata(rdata), .rvalid(rvalid),
    .pll_enable(pll_enable), .rx_cfg(rx_cfg), .lvds_cfg(lvds_cfg));
  dlb_host host (.mclk(mclk), .req(req), .rdata(rdata), .rvalid(rvalid));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic readall();
    for (int k = 0; k < 5; k++)
    begin
      host.rd(ofs[k], d);
      chk(d, m[k]);
    end
  endtask
  task automatic results();
    if (n_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ------------------------------
  // sequence
  // ------------------------------
  initial
  begin
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    m = rst;
    readall();
    host.rd(8'h00, d);
    chk(d, 8'h00);
    host.wr(8'h0c, 8'hff);
    readall();
    for (int c = 0; c < 4; c++)
    begin
      host.wr(8'h10, 8'(c << 3));
      host.wr(8'h11, 8'(c * 8'h44));
      // decoded outputs follow the stored byte one edge later
      @(posedge mclk);
      @(negedge mclk);
      chk(8'(rx_cfg.lanes_on), 8'h0f >> c);
      chk(8'(rx_cfg.clock_eq_db), (c == 3) ? 8'h02 : 8'(c == 1));
    end
    m[1] = 8'h18;
    m[2] = 8'hcc;
    repeat (40)
    begin
      r = xs();
      i = r % 5;
      m[i] = r[15:8];
      host.wr(ofs[i], m[i]);
      if (r[16])
        readall();
    end
    readall();
    m[3] = 8'h64;
    host.wr(ofs[3], m[3]);
    @(posedge mclk);
    @(negedge mclk);
    chk(rx_cfg.clock_range_code, 8'h64);
    chk(8'(pll_enable), 8'(m[0][0]));
    chk(8'(lvds_cfg), 8'({m[4][7:5], m[4][3], m[4][3]}));
    chk(rx_cfg.clock_range_code, m[3]);
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    m = rst;
    readall();
    results();
  end
  initial
  begin
    #200000;
    n_errors++;
    results();
  end
endmodule
`default_nettype wire
